// file: hw/sdrpin_fifo.sv
`timescale 1ns/1ns

// Dual-clock FIFO with gray-coded pointers; DEPTH must be a power of two, at least 4.
module sdrpin_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Filling side.
  input  wire logic             wr_clk,
  input  wire logic             wr_rstn,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  // Draining side.
  input  wire logic             rd_clk,
  input  wire logic             rd_rstn,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [WIDTH-1:0]      rd_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] far_s1;
    logic [AW:0] far_s2;
  } sdrpin_fptr_s;

  sdrpin_fptr_s     wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [WIDTH-1:0] mem [DEPTH];

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  // Full compares against the read pointer seen two flops late, so it is pessimistic, never wrong.
  always_comb begin
    wr_ready = wr_ff.gray != {~wr_ff.far_s2[AW:AW-1], wr_ff.far_s2[AW-2:0]};
    rd_valid = rd_ff.gray != rd_ff.far_s2;
    rd_data  = mem[rd_ff.bin[AW-1:0]];
  end

  // Pointer advance and the two-stage pointer synchronisers of both sides.
  always_comb begin
    nxt_wr        = wr_ff;
    nxt_wr.far_s1 = rd_ff.gray;
    nxt_wr.far_s2 = wr_ff.far_s1;
    if (wr_valid && wr_ready) begin
      nxt_wr.bin  = wr_ff.bin + 1'b1;
      nxt_wr.gray = bin2gray(wr_ff.bin + 1'b1);
    end
    nxt_rd        = rd_ff;
    nxt_rd.far_s1 = wr_ff.gray;
    nxt_rd.far_s2 = rd_ff.far_s1;
    if (rd_valid && rd_ready) begin
      nxt_rd.bin  = rd_ff.bin + 1'b1;
      nxt_rd.gray = bin2gray(rd_ff.bin + 1'b1);
    end
  end

  always_ff @(posedge wr_clk or negedge wr_rstn) begin
    if (!wr_rstn) begin
      wr_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
    end
  end

  // Storage has no reset; only the pointers decide what is valid.
  always_ff @(posedge wr_clk) begin
    if (wr_valid && wr_ready) begin
      mem[wr_ff.bin[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rstn) begin
    if (!rd_rstn) begin
      rd_ff <= '0;
    end else begin
      rd_ff <= nxt_rd;
    end
  end

endmodule : sdrpin_fifo

// file: hw/sdrpin_top.sv
`timescale 1ns/1ns
`include "sdrpin_consts.svh"

// Contract
// - On read or write, auto-precharge bit high closes the bank after the burst.
// - On precharge, auto-precharge bit low closes the selected bank, high closes all.
// - On read or write, burst-chop bit low chops the burst, high runs full.
// - Device drives strobe edge-aligned on reads; controller centres strobe on writes.
// - The strobe is always a complementary differential pair, never single-ended.
// - The reset pin acts asynchronously and destroys stored contents; here it clears the link state only and the storage array keeps its data.
// - Eight shared data lines; controller drives for writes, device for reads.
// - Address and control pins are sampled on the rising true clock.
// - Any command seen while rank select is high is ignored.
module sdrpin_top #(
  parameter int COL_W      = `SDRPIN_COL_W,
  parameter int FIFO_DEPTH = `SDRPIN_FIFO_DEPTH
) (
  // Core clock and reset.
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // Link clock (true leg of the pair) and device reset pin.
  input  wire logic                     diff_clock_pair_t,
  input  wire logic                     reset_n,
  // Command and address pins.
  input  wire sdrpin_pkg::sdrpin_cmdpins_s cmd_pins,
  // Data lines.
  input  wire logic [7:0]               data_lines_in,
  output logic [7:0]                    data_lines_out,
  output logic                          data_lines_oe_n,
  // Data strobe pair.
  input  wire logic                     strobe_t_in,
  input  wire logic                     strobe_c_in,
  output logic                          strobe_t_out,
  output logic                          strobe_c_out,
  output logic                          strobe_oe_n,
  // Link status.
  output logic                          strobe_err,
  output logic                          cmd_refused,
  output logic [7:0]                    bank_open,
  // Core-side command event stream.
  output logic                          evt_valid,
  output sdrpin_pkg::sdrpin_evt_s       evt_rec,
  input  wire logic                     evt_ready
);
  import sdrpin_pkg::*;

  localparam int MEM_AW    = 6 + COL_W;
  localparam int MEM_WORDS = 1 << MEM_AW;
  localparam int EVT_W     = $bits(sdrpin_evt_s);

  localparam sdrpin_link_s LINK_RST = '{
    st: SDRPIN_LS_IDLE, beat: 3'h0, last: `SDRPIN_LAST_FULL, bank: 3'h0, col: 15'h0000,
    ap: 1'b0, open_rows: `SDRPIN_OPEN_RST, dq_out: 8'h00, dq_oe_n: 1'b1, dqs_t: 1'b0,
    dqs_c: 1'b1, dqs_oe_n: 1'b1, strobe_prev: 1'b0, strobe_err: 1'b0, refused: 1'b0
  };

  sdrpin_link_s     link_ff;
  sdrpin_link_s     nxt_link;
  sdrpin_core_s     core_ff;
  sdrpin_core_s     nxt_core;
  logic [7:0]       mem [MEM_WORDS];
  logic [MEM_AW-1:0] rd_idx;
  logic [MEM_AW-1:0] wr_idx;
  logic [7:0]       rd_word;
  logic             mem_we;
  sdrpin_cmd_e      pin_cmd;
  logic             pin_ap;
  logic             pin_chop;
  logic             cmd_live;
  logic             cmd_take;
  logic             strobe_ok;
  sdrpin_evt_s      evt_in;
  logic             fifo_wr_ready;
  logic             fifo_rd_valid;
  logic [EVT_W-1:0] fifo_rd_data;
  logic             pop;

  // One byte per beat: bank, column and beat index form the word address.
  function automatic logic [MEM_AW-1:0] mem_index(input logic [2:0]  bank,
                                                  input logic [14:0] col,
                                                  input logic [2:0]  beat);
    mem_index = {bank, col[COL_W-1:0], beat};
  endfunction : mem_index

  // Decode the pins; commands that arrive during a burst are not taken.
  always_comb begin
    pin_cmd  = sdrpin_cmd_e'({cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n});
    pin_ap   = cmd_pins.addr[`SDRPIN_AP_BIT];
    pin_chop = !cmd_pins.addr[`SDRPIN_BC_BIT];
    cmd_live = !cmd_pins.cs_n && (link_ff.st == SDRPIN_LS_IDLE) &&
               (pin_cmd inside {SDRPIN_CMD_ACT, SDRPIN_CMD_RD, SDRPIN_CMD_WR, SDRPIN_CMD_PRE});
    // A full event FIFO refuses the command rather than losing its report.
    cmd_take = cmd_live && fifo_wr_ready;
    evt_in   = '{cmd: pin_cmd, bank: cmd_pins.bank, ap: pin_ap, chop: pin_chop};
  end

  // Array addresses: the first read beat comes from the pins at command time, later ones from the latched bank and column.
  always_comb begin
    if (link_ff.st == SDRPIN_LS_IDLE) begin
      rd_idx = mem_index(cmd_pins.bank, cmd_pins.addr, 3'h0);
    end else begin
      rd_idx = mem_index(link_ff.bank, link_ff.col, link_ff.beat + 3'h1);
    end
    wr_idx  = mem_index(link_ff.bank, link_ff.col, link_ff.beat);
    rd_word = mem[rd_idx];
    // A write beat counts only if the pair is complementary and has toggled.
    strobe_ok = (strobe_t_in != strobe_c_in) &&
                (strobe_t_in != link_ff.strobe_prev);
  end

  // Link state machine: command capture, burst counting, bus direction.
  always_comb begin
    nxt_link = link_ff;
    mem_we   = 1'b0;
    if (cmd_live && !fifo_wr_ready) begin
      nxt_link.refused = 1'b1;
    end
    case (link_ff.st)
      SDRPIN_LS_IDLE: begin
        if (cmd_take) begin
          case (pin_cmd)
            SDRPIN_CMD_ACT: begin
              nxt_link.open_rows[cmd_pins.bank] = 1'b1;
            end
            SDRPIN_CMD_PRE: begin
              if (pin_ap) begin
                nxt_link.open_rows = `SDRPIN_OPEN_RST;
              end else begin
                nxt_link.open_rows[cmd_pins.bank] = 1'b0;
              end
            end
            SDRPIN_CMD_RD: begin
              nxt_link.bank     = cmd_pins.bank;
              nxt_link.col      = cmd_pins.addr;
              nxt_link.ap       = pin_ap;
              nxt_link.beat     = 3'h0;
              nxt_link.last     = pin_chop ? `SDRPIN_LAST_CHOP : `SDRPIN_LAST_FULL;
              nxt_link.st       = SDRPIN_LS_READ;
              // Data and strobe change on the same edge: edge-aligned read.
              nxt_link.dq_out   = rd_word;
              nxt_link.dq_oe_n  = 1'b0;
              nxt_link.dqs_t    = ~link_ff.dqs_t;
              nxt_link.dqs_c    = link_ff.dqs_t;
              nxt_link.dqs_oe_n = 1'b0;
            end
            SDRPIN_CMD_WR: begin
              nxt_link.bank        = cmd_pins.bank;
              nxt_link.col         = cmd_pins.addr;
              nxt_link.ap          = pin_ap;
              nxt_link.beat        = 3'h0;
              nxt_link.last        = pin_chop ? `SDRPIN_LAST_CHOP : `SDRPIN_LAST_FULL;
              nxt_link.st          = SDRPIN_LS_WRITE;
              nxt_link.strobe_prev = strobe_t_in;
            end
            default: begin
              nxt_link.st = SDRPIN_LS_IDLE;
            end
          endcase
        end
      end
      SDRPIN_LS_READ: begin
        if (link_ff.beat == link_ff.last) begin
          nxt_link.st       = SDRPIN_LS_IDLE;
          nxt_link.dq_oe_n  = 1'b1;
          nxt_link.dqs_oe_n = 1'b1;
          if (link_ff.ap) begin
            nxt_link.open_rows[link_ff.bank] = 1'b0;
          end
        end else begin
          nxt_link.beat   = link_ff.beat + 3'h1;
          nxt_link.dq_out = rd_word;
          nxt_link.dqs_t  = ~link_ff.dqs_t;
          nxt_link.dqs_c  = link_ff.dqs_t;
        end
      end
      SDRPIN_LS_WRITE: begin
        // The controller owns the strobe here; its level is checked each beat.
        mem_we               = strobe_ok;
        nxt_link.strobe_prev = strobe_t_in;
        if (!strobe_ok) begin
          nxt_link.strobe_err = 1'b1;
        end
        if (link_ff.beat == link_ff.last) begin
          nxt_link.st = SDRPIN_LS_IDLE;
          if (link_ff.ap) begin
            nxt_link.open_rows[link_ff.bank] = 1'b0;
          end
        end else begin
          nxt_link.beat = link_ff.beat + 3'h1;
        end
      end
      default: begin
        nxt_link = LINK_RST;
      end
    endcase
  end

  // The reset pin clears the link at once; rows close and the array is left stale.
  always_ff @(posedge diff_clock_pair_t or negedge reset_n) begin
    if (!reset_n) begin
      link_ff <= LINK_RST;
    end else begin
      link_ff <= nxt_link;
    end
  end

  // Storage array, written one byte per accepted write beat.
  always_ff @(posedge diff_clock_pair_t) begin
    if (mem_we) begin
      mem[wr_idx] <= data_lines_in;
    end
  end

  // Command reports cross to the core clock through the gray-pointer FIFO.
  sdrpin_fifo #(
    .WIDTH (EVT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_evt_fifo (
    .wr_clk   (diff_clock_pair_t),
    .wr_rstn  (reset_n),
    .wr_valid (cmd_take),
    .wr_ready (fifo_wr_ready),
    .wr_data  (evt_in),
    .rd_clk   (clk),
    .rd_rstn  (rstn),
    .rd_valid (fifo_rd_valid),
    .rd_ready (pop),
    .rd_data  (fifo_rd_data)
  );

  // Core output register: refills whenever empty or being drained.
  always_comb begin
    pop      = fifo_rd_valid && (!core_ff.valid || evt_ready);
    nxt_core = core_ff;
    if (pop) begin
      nxt_core.valid = 1'b1;
      nxt_core.rec   = sdrpin_evt_s'(fifo_rd_data);
    end else if (evt_ready) begin
      nxt_core.valid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_ff <= '0;
    end else begin
      core_ff <= nxt_core;
    end
  end

  // Every output is a flip-flop of one of the two state structs.
  assign data_lines_out  = link_ff.dq_out;
  assign data_lines_oe_n = link_ff.dq_oe_n;
  assign strobe_t_out    = link_ff.dqs_t;
  assign strobe_c_out    = link_ff.dqs_c;
  assign strobe_oe_n     = link_ff.dqs_oe_n;
  assign strobe_err      = link_ff.strobe_err;
  assign cmd_refused     = link_ff.refused;
  assign bank_open       = link_ff.open_rows;
  assign evt_valid       = core_ff.valid;
  assign evt_rec         = core_ff.rec;

  // Checks on the link side, plus the event hold check on the core side.
  a_cs_high_ignored: assert property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    cmd_pins.cs_n && link_ff.st == SDRPIN_LS_IDLE |=> $stable(link_ff.open_rows)
      && link_ff.st == SDRPIN_LS_IDLE)
    else $error("Command taken while rank select was high.");

  a_read_full_len: assert property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    cmd_take && pin_cmd == SDRPIN_CMD_RD && !pin_chop
      |-> ##1 (!link_ff.dq_oe_n) [*8] ##1 link_ff.dq_oe_n)
    else $error("Full read burst did not drive exactly eight beats.");

  a_read_chop_len: assert property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    cmd_take && pin_cmd == SDRPIN_CMD_RD && pin_chop
      |-> ##1 (!link_ff.dq_oe_n) [*4] ##1 link_ff.dq_oe_n)
    else $error("Chopped read burst did not drive exactly four beats.");

  a_auto_pre_close: assert property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    cmd_take && pin_cmd inside {SDRPIN_CMD_RD, SDRPIN_CMD_WR} && pin_ap && !pin_chop
      |-> ##9 !link_ff.open_rows[$past(cmd_pins.bank, 9)])
    else $error("Bank still open after auto-precharge burst.");

  a_no_ap_open: assert property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    cmd_take && pin_cmd == SDRPIN_CMD_RD && !pin_ap && link_ff.open_rows[cmd_pins.bank]
      |-> ##5 link_ff.open_rows[$past(cmd_pins.bank, 5)])
    else $error("Row closed by a read without auto-precharge.");

  a_pre_all_close: assert property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    cmd_take && pin_cmd == SDRPIN_CMD_PRE && pin_ap |=> link_ff.open_rows == 8'h00)
    else $error("Precharge-all left a bank open.");

  a_pre_one_bank: assert property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    cmd_take && pin_cmd == SDRPIN_CMD_PRE && !pin_ap
      |=> link_ff.open_rows == ($past(link_ff.open_rows) & ~(8'h01 << $past(cmd_pins.bank))))
    else $error("Single-bank precharge touched the wrong banks.");

  a_strobe_pair: assert property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    !link_ff.dqs_oe_n |-> link_ff.dqs_t != link_ff.dqs_c)
    else $error("Driven strobe legs are not complementary.");

  a_strobe_aligned: assert property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    !link_ff.dq_oe_n && !$past(link_ff.dq_oe_n) |-> link_ff.dqs_t != $past(link_ff.dqs_t))
    else $error("Read beat changed without a strobe edge.");

  a_bus_direction: assert property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    link_ff.st == SDRPIN_LS_WRITE |-> link_ff.dq_oe_n && link_ff.dqs_oe_n)
    else $error("Device drives the bus during a write burst.");

  a_reset_clear: assert property (@(posedge diff_clock_pair_t)
    $rose(reset_n) |-> link_ff.open_rows == 8'h00 && link_ff.dq_oe_n)
    else $error("Link state survived the reset pin.");

  a_evt_hold: assert property (@(posedge clk) disable iff (!rstn)
    evt_valid && !evt_ready |=> evt_valid && $stable(evt_rec))
    else $error("Event dropped or changed while stalled.");

  c_read_full: cover property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    cmd_take && pin_cmd == SDRPIN_CMD_RD && !pin_chop);
  c_write_chop: cover property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    cmd_take && pin_cmd == SDRPIN_CMD_WR && pin_chop);
  c_pre_all: cover property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    cmd_take && pin_cmd == SDRPIN_CMD_PRE && pin_ap);
  c_refused: cover property (@(posedge diff_clock_pair_t) disable iff (!reset_n)
    cmd_live && !fifo_wr_ready);

endmodule : sdrpin_top

// file: include/sdrpin_consts.svh
`ifndef SDRPIN_CONSTS_SVH
`define SDRPIN_CONSTS_SVH

// Positions of the qualifier bits inside the address pins.
`define SDRPIN_AP_BIT      10
`define SDRPIN_BC_BIT      12

// Last beat index of a full and of a chopped burst (eight and four beats).
`define SDRPIN_LAST_FULL   3'h7
`define SDRPIN_LAST_CHOP   3'h3

// Reset value of the open-row mask: every bank closed.
`define SDRPIN_OPEN_RST    8'h00

// Column bits kept by the small storage array, and depth of the event FIFO.
`define SDRPIN_COL_W       4
`define SDRPIN_FIFO_DEPTH  8

`endif

// file: include/sdrpin_pkg.sv
package sdrpin_pkg;

  // Command code as {row strobe, column strobe, write enable}, all active low.
  typedef enum logic [2:0] {
    SDRPIN_CMD_ACT = 3'h3,
    SDRPIN_CMD_RD  = 3'h5,
    SDRPIN_CMD_WR  = 3'h4,
    SDRPIN_CMD_PRE = 3'h2,
    SDRPIN_CMD_NOP = 3'h7
  } sdrpin_cmd_e;

  // Link-side burst state.
  typedef enum logic [1:0] {
    SDRPIN_LS_IDLE  = 2'h0,
    SDRPIN_LS_READ  = 2'h1,
    SDRPIN_LS_WRITE = 2'h2
  } sdrpin_lstate_e;

  // Command and address pins as sampled on the rising link clock.
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  bank;
    logic [14:0] addr;
  } sdrpin_cmdpins_s;

  // One accepted command, as reported to the core side.
  typedef struct packed {
    sdrpin_cmd_e cmd;
    logic [2:0]  bank;
    logic        ap;
    logic        chop;
  } sdrpin_evt_s;

  // Whole state of the link-clock domain.
  typedef struct packed {
    sdrpin_lstate_e st;
    logic [2:0]     beat;
    logic [2:0]     last;
    logic [2:0]     bank;
    logic [14:0]    col;
    logic           ap;
    logic [7:0]     open_rows;
    logic [7:0]     dq_out;
    logic           dq_oe_n;
    logic           dqs_t;
    logic           dqs_c;
    logic           dqs_oe_n;
    logic           strobe_prev;
    logic           strobe_err;
    logic           refused;
  } sdrpin_link_s;

  // Whole state of the core-clock domain: the output holding register.
  typedef struct packed {
    logic        valid;
    sdrpin_evt_s rec;
  } sdrpin_core_s;

endpackage : sdrpin_pkg

// file: verif/sdrpin_ctrl_model.sv
`timescale 1ns/1ns

// Controller model: drives command pins, write data and strobe off the link falling edge.
module sdrpin_ctrl_model
  import sdrpin_pkg::*;
(
  // Link clock and device reset pin.
  input  wire logic                    lclk,
  output logic                         reset_n,
  // Pins toward the device.
  output sdrpin_pkg::sdrpin_cmdpins_s  cmd_pins,
  output logic [7:0]                   dq_drv,
  output logic                         dqs_t,
  output logic                         dqs_c,
  // Wire levels seen back: data, {data oe_n, strobe oe_n, strobe t, strobe c}.
  input  wire logic [7:0]              dq_wire,
  input  wire logic [3:0]              dev_pins
);
  import sdrpin_pkg::*;
  logic [7:0] wr_byte [8];
  logic [7:0] rd_byte [8];
  logic [3:0] rd_pins [9];

  // Power-up: reset pin low, chip select high.
  initial begin
    reset_n  = 1'b0;
    cmd_pins = 22'h3F_FFFF;
    dq_drv   = 8'h00;
    dqs_t    = 1'b0;
    dqs_c    = 1'b0;
  end

  // Reset pin stays high in normal operation; low only for a destructive reset.
  task automatic set_reset(input logic v);
    @(negedge lclk);
    reset_n = v;
  endtask : set_reset

  // One command stands from this falling edge until the next call.
  task automatic send(input logic cs_n, input sdrpin_cmd_e c, input logic [2:0] b,
                      input logic [14:0] a);
    @(negedge lclk);
    cmd_pins = {cs_n, c, b, a};
  endtask : send

  // Released lines do not keep their last level, so scramble them every cycle.
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge lclk);
      cmd_pins = {1'b1, ~cmd_pins[20:0]};
      dq_drv = ~dq_drv;
      {dqs_t, dqs_c} = {~dqs_t, ~dqs_t};
    end
  endtask : idle

  // Column access; bad keeps the strobe still on the last write beat.
  task automatic burst(input logic wr, input logic [2:0] b, input logic [3:0] col,
                       input logic ap, input logic chop, input logic bad);
    int n;
    n = chop ? 4 : 8;
    send(1'b0, wr ? SDRPIN_CMD_WR : SDRPIN_CMD_RD, b,
         {2'b00, ~chop, 1'b0, ap, 6'h00, col});
    for (int k = 0; k < n; k++) begin
      @(negedge lclk);
      cmd_pins = {1'b1, ~cmd_pins[20:0]};
      rd_byte[k] = dq_wire;
      rd_pins[k] = dev_pins;
      if (wr) begin
        dq_drv = wr_byte[k];
        dqs_t = (bad && k == n - 1) ? dqs_t : ~dqs_t;
        dqs_c = ~dqs_t;
      end else begin
        dq_drv = ~dq_drv;
        {dqs_t, dqs_c} = {~dqs_t, ~dqs_t};
      end
    end
    idle(1);
    rd_pins[n] = dev_pins;
  endtask : burst
endmodule : sdrpin_ctrl_model

// file: verif/sdrpin_top_tb_top.sv
`timescale 1ns/1ns

// Bench: command pin block against the controller model, core events drained here.
module sdrpin_top_tb_top;
  import sdrpin_pkg::*;
  logic            clk, rstn, lclk, evt_ready, reset_n, evt_valid;
  logic            dqs_t, dqs_c, st_t, st_c, st_oe_n, dq_oe_n, strobe_err, cmd_refused;
  logic [7:0]      dq_drv, dq_out, dq_wire, bank_open;
  logic            wt, wc;
  sdrpin_cmdpins_s cmd_pins;
  sdrpin_evt_s     evt_rec;
  sdrpin_evt_s     evq [$];
  int              miscompares = 0;
  int              compares = 0;

  // Shared wires: whoever has its enable low owns the line.
  assign dq_wire = dq_oe_n ? dq_drv : dq_out;
  assign wt = st_oe_n ? dqs_t : st_t;
  assign wc = st_oe_n ? dqs_c : st_c;

  sdrpin_top sdrpin_top_i (
    .clk(clk), .rstn(rstn), .diff_clock_pair_t(lclk), .reset_n(reset_n),
    .cmd_pins(cmd_pins), .data_lines_in(dq_wire), .data_lines_out(dq_out),
    .data_lines_oe_n(dq_oe_n), .strobe_t_in(wt), .strobe_c_in(wc),
    .strobe_t_out(st_t), .strobe_c_out(st_c), .strobe_oe_n(st_oe_n),
    .strobe_err(strobe_err), .cmd_refused(cmd_refused), .bank_open(bank_open),
    .evt_valid(evt_valid), .evt_rec(evt_rec), .evt_ready(evt_ready)
  );

  sdrpin_ctrl_model sdrpin_ctrl_model_i (
    .lclk(lclk), .reset_n(reset_n), .cmd_pins(cmd_pins), .dq_drv(dq_drv),
    .dqs_t(dqs_t), .dqs_c(dqs_c), .dq_wire(dq_wire), .dev_pins({dq_oe_n, st_oe_n, wt, wc})
  );

  // Core clock, and a link clock of unrelated phase.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #15 lclk = ~lclk;
  end

  // Every event the core side takes, in order.
  always @(posedge clk) begin
    if (rstn && evt_valid === 1'b1 && evt_ready === 1'b1) evq.push_back(evt_rec);
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic cmd(input logic cs_n, input sdrpin_cmd_e c, input logic [2:0] b,
                     input logic ap);
    // Burst-chop pin held high so that row and precharge commands report no chop.
    sdrpin_ctrl_model_i.send(cs_n, c, b, {4'h2, ap, 10'h000});
  endtask : cmd

  // Waits a bounded time for the next event and compares it whole.
  task automatic expect_evt(input sdrpin_cmd_e c, input logic [2:0] b, input logic ap,
                            input logic ch);
    for (int i = 0; i < 40 && evq.size() == 0; i++) @(negedge clk);
    if (evq.size() == 0) check(8'h00, {c, b, ap, ch}, "event missing");
    else check(evq.pop_front(), {c, b, ap, ch}, "event");
  endtask : expect_evt

  task automatic check_read(input int n, input logic [7:0] base);
    for (int k = 0; k < n; k++) begin
      check(sdrpin_ctrl_model_i.rd_byte[k], base + 8'(k), "read byte");
      check(sdrpin_ctrl_model_i.rd_pins[k][3:2], 2'b00, "device drives");
      check(sdrpin_ctrl_model_i.rd_pins[k][0] ^ sdrpin_ctrl_model_i.rd_pins[k][1], 1'b1,
            "pair");
      if (k > 0) check(sdrpin_ctrl_model_i.rd_pins[k][1] ^ sdrpin_ctrl_model_i.rd_pins[k-1][1],
                       1'b1, "toggle");
    end
    check(sdrpin_ctrl_model_i.rd_pins[n][3:2], 2'b11, "burst end");
  endtask : check_read

  task automatic sc_reset_values();
    @(negedge lclk);
    check({dq_oe_n, st_oe_n, st_t, st_c, bank_open[3:0]}, 8'hD0, "idle pins");
    check({strobe_err, cmd_refused, bank_open[7:4]}, 8'h00, "idle flags");
  endtask : sc_reset_values

  // Rank select high is ignored; precharge of one bank, then of all.
  task automatic sc_banks();
    cmd(1'b0, SDRPIN_CMD_ACT, 3'h1, 1'b0);
    cmd(1'b0, SDRPIN_CMD_ACT, 3'h3, 1'b0);
    cmd(1'b0, SDRPIN_CMD_ACT, 3'h6, 1'b0);
    cmd(1'b1, SDRPIN_CMD_ACT, 3'h0, 1'b0);
    cmd(1'b0, SDRPIN_CMD_PRE, 3'h1, 1'b0);
    sdrpin_ctrl_model_i.idle(3);
    check(bank_open, 8'h48, "one bank closed");
    cmd(1'b0, SDRPIN_CMD_PRE, 3'h2, 1'b1);
    sdrpin_ctrl_model_i.idle(3);
    check(bank_open, 8'h00, "all closed");
    expect_evt(SDRPIN_CMD_ACT, 3'h1, 1'b0, 1'b0);
    expect_evt(SDRPIN_CMD_ACT, 3'h3, 1'b0, 1'b0);
    expect_evt(SDRPIN_CMD_ACT, 3'h6, 1'b0, 1'b0);
    expect_evt(SDRPIN_CMD_PRE, 3'h1, 1'b0, 1'b0);
    expect_evt(SDRPIN_CMD_PRE, 3'h2, 1'b1, 1'b0);
  endtask : sc_banks

  // Full bursts without auto precharge, then chopped ones with it.
  task automatic sc_bursts();
    for (int k = 0; k < 8; k++) sdrpin_ctrl_model_i.wr_byte[k] = 8'hA0 + 8'(k);
    cmd(1'b0, SDRPIN_CMD_ACT, 3'h3, 1'b0);
    sdrpin_ctrl_model_i.burst(1'b1, 3'h3, 4'h5, 1'b0, 1'b0, 1'b0);
    sdrpin_ctrl_model_i.burst(1'b0, 3'h3, 4'h5, 1'b0, 1'b0, 1'b0);
    check_read(8, 8'hA0);
    sdrpin_ctrl_model_i.idle(2);
    check(bank_open, 8'h08, "row kept open");
    for (int k = 0; k < 8; k++) sdrpin_ctrl_model_i.wr_byte[k] = 8'h50 + 8'(k);
    cmd(1'b0, SDRPIN_CMD_ACT, 3'h6, 1'b0);
    sdrpin_ctrl_model_i.burst(1'b1, 3'h6, 4'h9, 1'b1, 1'b1, 1'b0);
    sdrpin_ctrl_model_i.idle(2);
    check(bank_open, 8'h08, "closed after write");
    cmd(1'b0, SDRPIN_CMD_ACT, 3'h6, 1'b0);
    sdrpin_ctrl_model_i.burst(1'b0, 3'h6, 4'h9, 1'b1, 1'b1, 1'b0);
    check_read(4, 8'h50);
    sdrpin_ctrl_model_i.idle(2);
    check(bank_open | {7'h00, strobe_err}, 8'h08, "closed after read");
    expect_evt(SDRPIN_CMD_ACT, 3'h3, 1'b0, 1'b0);
    expect_evt(SDRPIN_CMD_WR, 3'h3, 1'b0, 1'b0);
    expect_evt(SDRPIN_CMD_RD, 3'h3, 1'b0, 1'b0);
    expect_evt(SDRPIN_CMD_ACT, 3'h6, 1'b0, 1'b0);
    expect_evt(SDRPIN_CMD_WR, 3'h6, 1'b1, 1'b1);
    expect_evt(SDRPIN_CMD_ACT, 3'h6, 1'b0, 1'b0);
    expect_evt(SDRPIN_CMD_RD, 3'h6, 1'b1, 1'b1);
  endtask : sc_bursts

  // A write beat whose strobe fails to toggle is flagged; auto precharge ends a full write.
  task automatic sc_strobe_err();
    cmd(1'b0, SDRPIN_CMD_ACT, 3'h2, 1'b0);
    sdrpin_ctrl_model_i.burst(1'b1, 3'h2, 4'h0, 1'b1, 1'b0, 1'b1);
    sdrpin_ctrl_model_i.idle(2);
    check({strobe_err, bank_open[6:0]}, 8'h88, "strobe fault");
    expect_evt(SDRPIN_CMD_ACT, 3'h2, 1'b0, 1'b0);
    expect_evt(SDRPIN_CMD_WR, 3'h2, 1'b1, 1'b0);
  endtask : sc_strobe_err

  // Core stalls until the event buffer refuses, then drains it.
  task automatic sc_fifo_full();
    @(negedge clk);
    evt_ready = 1'b0;
    for (int k = 0; k < 12; k++) cmd(1'b0, SDRPIN_CMD_ACT, 3'(k), 1'b0);
    sdrpin_ctrl_model_i.idle(3);
    check(cmd_refused, 1'b1, "buffer refusal");
    @(negedge clk);
    evt_ready = 1'b1;
    repeat (60) @(negedge clk);
    check(evq.size() inside {8, 9}, 1'b1, "events held");
    for (int k = 0; k < 8; k++) expect_evt(SDRPIN_CMD_ACT, 3'(k), 1'b0, 1'b0);
    evq.delete();
  endtask : sc_fifo_full

  // Reset in mid-run clears the link state; the link works again afterwards.
  task automatic sc_reset_mid();
    @(negedge clk);
    rstn = 1'b0;
    sdrpin_ctrl_model_i.set_reset(1'b0);
    // Let the asynchronous clear settle before looking at the flops.
    @(negedge clk);
    check(bank_open | {6'h00, strobe_err, cmd_refused}, 8'h00, "reset state");
    sdrpin_ctrl_model_i.set_reset(1'b1);
    @(negedge clk);
    rstn = 1'b1;
    cmd(1'b0, SDRPIN_CMD_ACT, 3'h5, 1'b0);
    sdrpin_ctrl_model_i.idle(3);
    check(bank_open, 8'h20, "after reset");
    expect_evt(SDRPIN_CMD_ACT, 3'h5, 1'b0, 1'b0);
  endtask : sc_reset_mid

  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // Main sequence.
  initial begin
    rstn = 1'b0;
    evt_ready = 1'b1;
    repeat (20) @(negedge clk);
    sdrpin_ctrl_model_i.set_reset(1'b1);
    @(negedge clk);
    rstn = 1'b1;
    sc_reset_values();
    sc_banks();
    sc_bursts();
    sc_strobe_err();
    sc_fifo_full();
    sc_reset_mid();
    report_and_stop();
  end

  // Watchdog: the whole run needs a few hundred cycles, so this only cuts a hang.
  initial begin
    #500_000;
    miscompares++;
    report_and_stop();
  end
endmodule : sdrpin_top_tb_top
